/* File: rtl/biopotential_aux_config_regs.sv */
// aux configuration register bank with breathing control generator
`timescale 1ns/1ps
`default_nettype none
`include "aux_cfg_defs.svh"

// Overview of operation
// - phase field sets second output lag, 22.5 degrees per step, 000 is 22.5
// - phase field resets to 101, a 135 degree offset
// - phase setting ignored when conversion rate is below 32 kSPS
// - mode 00 no breathing, 01 external breathing (reset); only bit 0 is decoded, so 10 acts as 00 and 11 as 01
// - frequency field bits 7:5 give 64 kHz at 000, halving down to 500 Hz
// - frequency codes 010 and up force 180 degrees; 000 and 001 use phase
// - frequencies scale with the master clock, nominal 2.048 MHz
// - setup bit 3 selects single-shot when 1, continuous when 0 (reset)
// - setup bit 2 links central terminal to the drive path when 1
// - setup bit 1 enables lead-off comparators when 1, reset 0
// - bit 7 routes A/B average to ch6, bit 6 A/C average to ch5
// - bit 5 routes B/C average to ch7, bit 4 to ch4
// - first terminal bit 3 powers buffer A when 1, reset 0
// - buffer select: upper bits channel minus one, low bit negative input
// - second terminal bit 7 powers buffer C, bit 6 buffer B
// - buffer B select in bits 5:3, resets to 010
// - buffer C select in bits 2:0, resets to 100
// - channel code 110 drives body input onto positive, 111 onto negative
// - breathing modes 01 or 11 take over general pins 2, 3 and 4
// - channel code 010 with measure enable routes drive signal into channel
module biopotential_aux_config_regs #(
  parameter int unsigned MASTER_HZ = `MASTER_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic breathing_out_first,
  output logic breathing_out_second,
  output logic gpio_taken,
  output logic single_shot,
  output logic terminal_to_drive_link,
  output logic lead_comparator_enable,
  output logic [3:0] augmented_lead_route,
  output logic [2:0] buffer_power,
  output logic [8:0] buffer_input_sel,
  output logic drive_to_positive,
  output logic drive_to_negative,
  output logic drive_to_measure
);
  import aux_cfg_pkg::*;

  // input select field width per buffer
  localparam int unsigned SEL_W = 3;
  // cycles of pclk per tick of the 16-step phase wheel at 64 kHz
  localparam int unsigned BASE_DIV =
    32'((`PCLK_HZ * 64'd1) / (64'(MASTER_HZ) * `BREATH_BASE_HZ * `PHASE_STEPS / `MASTER_CLK_HZ));
  localparam logic [15:0] BASE_DIV_W = (BASE_DIV < 1) ? 16'h0001 : 16'(BASE_DIV);

  reg8_t breathing_control_reg;
  reg8_t misc_setup_reg;
  reg8_t central_a_reg;
  reg8_t central_bc_reg;
  reg8_t channel_sel_reg;
  reg8_t rate_ctrl_reg;
  reg8_t rd_next;
  logic [7:0] idx;
  logic addr_ok;
  logic wr_en;
  logic [15:0] div_cnt_reg;
  logic tick;
  logic [7:0] octave_cnt_reg;
  logic step_en;
  logic [3:0] wheel_reg;
  logic [3:0] lag;
  logic [3:0] second_pos;
  logic breath_on;
  logic [2:0] freq;
  logic [2:0] phase;

  // decodes a word address into the register index
  function automatic logic [7:0] word_index(input logic [11:0] a);
    word_index = a[9:2];
  endfunction : word_index

  assign idx = word_index(paddr);
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                   (idx >= `BREATHING_CONTROL_IDX) && (idx <= `STATUS_IDX);
  // the write takes effect in the access phase, answered with zero wait states
  assign wr_en = psel && penable && pwrite && addr_ok;

  // apb answer: ready at every access, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // read mux
  always_comb begin
    rd_next = 8'h00;
    unique case (idx)
      `BREATHING_CONTROL_IDX: rd_next = breathing_control_reg;
      `MISC_SETUP_IDX: rd_next = misc_setup_reg;
      `CENTRAL_TERMINAL_A_IDX: rd_next = central_a_reg;
      `CENTRAL_TERMINAL_BC_IDX: rd_next = central_bc_reg;
      `CHANNEL_SEL_IDX: rd_next = channel_sel_reg;
      `RATE_CTRL_IDX: rd_next = rate_ctrl_reg;
      `STATUS_IDX: rd_next = {4'h0, wheel_reg[3], breathing_out_second,
                              breathing_out_first, gpio_taken};
      default: rd_next = 8'h00;
    endcase
  end

  // read data registered during setup so it is valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && addr_ok) begin
      prdata <= {24'h00_0000, rd_next};
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
    end
  end

  // breathing control register, must-be-zero bits held low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breathing_control_reg <= `BREATHING_CONTROL_RST;
    end else if (wr_en && idx == `BREATHING_CONTROL_IDX) begin
      breathing_control_reg <= pwdata[7:0] & `BREATHING_CONTROL_MASK;
    end
  end

  // misc setup register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_setup_reg <= `MISC_SETUP_RST;
    end else if (wr_en && idx == `MISC_SETUP_IDX) begin
      misc_setup_reg <= pwdata[7:0] & `MISC_SETUP_MASK;
    end
  end

  // central terminal registers, all bits writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      central_a_reg <= `CENTRAL_TERMINAL_A_RST;
      central_bc_reg <= `CENTRAL_TERMINAL_BC_RST;
    end else if (wr_en) begin
      if (idx == `CENTRAL_TERMINAL_A_IDX) begin
        central_a_reg <= pwdata[7:0];
      end
      if (idx == `CENTRAL_TERMINAL_BC_IDX) begin
        central_bc_reg <= pwdata[7:0];
      end
    end
  end

  // channel select: bits 2:0 mux code, bit 3 measure enable
  // rate control: bit 0 set when conversion rate is 32 kSPS
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_sel_reg <= `CHANNEL_SEL_RST;
      rate_ctrl_reg <= `RATE_CTRL_RST;
    end else if (wr_en) begin
      if (idx == `CHANNEL_SEL_IDX) begin
        channel_sel_reg <= pwdata[7:0] & `CHANNEL_SEL_MASK;
      end
      if (idx == `RATE_CTRL_IDX) begin
        rate_ctrl_reg <= {7'h00, pwdata[0]};
      end
    end
  end

  assign freq = breathing_control_reg[7:5] | misc_setup_reg[`FREQ_LSB +: 3];
  assign phase = breathing_control_reg[`PHASE_LSB +: 3];
  assign breath_on = breathing_control_reg[`MODE_LSB] ;

  // base divider: tick at 16 times 64 kHz scaled with the master clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 16'h0000;
    end else if (div_cnt_reg >= BASE_DIV_W - 16'h0001) begin
      div_cnt_reg <= 16'h0000;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end
  assign tick = (div_cnt_reg == 16'h0000);

  // octave prescaler: each frequency code halves the wheel rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      octave_cnt_reg <= 8'h00;
    end else if (tick) begin
      octave_cnt_reg <= octave_cnt_reg + 8'h01;
    end
  end
  assign step_en = tick && ((octave_cnt_reg & ((8'h01 << freq) - 8'h01)) == 8'h00);

  // phase wheel: 16 steps per breathing period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wheel_reg <= 4'h0;
    end else if (!breath_on) begin
      wheel_reg <= 4'h0;
    end else if (step_en) begin
      wheel_reg <= wheel_reg + 4'h1;
    end
  end

  // lag in sixteenths of a period; 180 degrees is 8
  always_comb begin
    if (freq >= 3'h2 || !rate_ctrl_reg[0]) begin
      lag = 4'h8;
    end else begin
      lag = 4'({1'b0, phase} + 4'h1);
    end
  end
  assign second_pos = wheel_reg - lag;

  // breathing outputs and pin takeover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breathing_out_first <= 1'b0;
      breathing_out_second <= 1'b0;
      gpio_taken <= 1'b0;
    end else begin
      breathing_out_first <= breath_on && !wheel_reg[3];
      breathing_out_second <= breath_on && !second_pos[3];
      gpio_taken <= breath_on;
    end
  end

  // static control outputs decoded from the fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_shot <= 1'b0;
      terminal_to_drive_link <= 1'b0;
      lead_comparator_enable <= 1'b0;
      augmented_lead_route <= 4'h0;
      buffer_power <= 3'h0;
      buffer_input_sel <= 9'h000;
      drive_to_positive <= 1'b0;
      drive_to_negative <= 1'b0;
      drive_to_measure <= 1'b0;
    end else begin
      single_shot <= misc_setup_reg[3];
      terminal_to_drive_link <= misc_setup_reg[2];
      lead_comparator_enable <= misc_setup_reg[1];
      augmented_lead_route <= central_a_reg[7:4];
      buffer_power <= {central_bc_reg[7], central_bc_reg[6], central_a_reg[3]};
      buffer_input_sel <= {central_bc_reg[2:0], central_bc_reg[5:3],
                           central_a_reg[SEL_W-1:0]};
      drive_to_positive <= channel_sel_reg[2:0] == `MUX_DRIVE_POS;
      drive_to_negative <= channel_sel_reg[2:0] == `MUX_DRIVE_NEG;
      drive_to_measure <= (channel_sel_reg[2:0] == `MUX_DRIVE_MEASURE) &&
                          channel_sel_reg[3];
    end
  end
endmodule : biopotential_aux_config_regs
`default_nettype wire

/* File: rtl/aux_cfg_defs.svh */
// register offsets, field positions, reset values and timing figures of the aux config bank
`ifndef AUX_CFG_DEFS_SVH
`define AUX_CFG_DEFS_SVH

// byte addresses are four times the printed register index
`define BREATHING_CONTROL_IDX 8'h16
`define MISC_SETUP_IDX 8'h17
`define CENTRAL_TERMINAL_A_IDX 8'h18
`define CENTRAL_TERMINAL_BC_IDX 8'h19
`define CHANNEL_SEL_IDX 8'h1A
`define RATE_CTRL_IDX 8'h1B
`define STATUS_IDX 8'h1C

`define BREATHING_CONTROL_RST 8'h15
`define MISC_SETUP_RST 8'h00
`define CENTRAL_TERMINAL_A_RST 8'h00
`define CENTRAL_TERMINAL_BC_RST 8'h14
`define CHANNEL_SEL_RST 8'h00
`define RATE_CTRL_RST 8'h00

// writable masks: must-be-zero bits are forced low
`define BREATHING_CONTROL_MASK 8'h1F
`define MISC_SETUP_MASK 8'hEE
`define CHANNEL_SEL_MASK 8'h3F

`define PHASE_LSB 2
`define MODE_LSB 0
`define FREQ_LSB 5

`define MODE_NONE 2'h0
`define MODE_EXTERNAL 2'h1
`define MUX_DRIVE_MEASURE 3'h2
`define MUX_DRIVE_POS 3'h6
`define MUX_DRIVE_NEG 3'h7

// breathing clock: master clock 2.048 MHz gives 64 kHz at code 000
`define MASTER_CLK_HZ 2048000
`define PCLK_HZ 20000000
`define BREATH_BASE_HZ 64000
`define PHASE_STEPS 16

`endif

/* File: rtl/aux_cfg_pkg.sv */
// types for the aux config bank
package aux_cfg_pkg;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_SETUP = 2'b01,
    APB_ACCESS = 2'b11
  } apb_state_t;

  typedef logic [7:0] reg8_t;
endpackage : aux_cfg_pkg

/* File: tb/aux_cfg_assertions.sv */
// checker for bus answers and register-to-pin mapping of the aux config bank
`timescale 1ns/1ps
`default_nettype none
module aux_cfg_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic gpio_taken,
  input wire logic single_shot,
  input wire logic terminal_to_drive_link,
  input wire logic lead_comparator_enable,
  input wire logic [3:0] augmented_lead_route,
  input wire logic [2:0] buffer_power,
  input wire logic [8:0] buffer_input_sel,
  input wire logic drive_to_positive,
  input wire logic drive_to_negative,
  input wire logic drive_to_measure
);
  logic [31:0] wd_q1;
  logic [31:0] wd_q2;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write data delayed two cycles to line up with the output lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_q1 <= '0;
      wd_q2 <= '0;
    end else begin
      wd_q1 <= pwdata;
      wd_q2 <= wd_q1;
    end
  end
  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("no answer in access phase");
  AST_REFUSE: assert property (psel && penable |-> pslverr ==
    (paddr[1:0] != 2'h0 || paddr < 12'h058 || paddr > 12'h070)) else $error("bad error flag");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_SEL_RESET: assert property ($rose(presetn) |=> buffer_input_sel == 9'h110)
    else $error("buffer select reset wrong");
  AST_SETUP_MAP: assert property (psel && penable && pwrite && paddr == 12'h05C |-> ##2
    {single_shot, terminal_to_drive_link, lead_comparator_enable} == wd_q2[3:1])
    else $error("setup outputs wrong");
  AST_MODE_PINS: assert property (psel && penable && pwrite && paddr == 12'h058 |-> ##2
    gpio_taken == wd_q2[0]) else $error("pin takeover wrong");
  AST_FIRST_TERM: assert property (psel && penable && pwrite && paddr == 12'h060 |-> ##2
    {augmented_lead_route, buffer_power[0], buffer_input_sel[2:0]} == wd_q2[7:0])
    else $error("first terminal outputs wrong");
  AST_SECOND_TERM: assert property (psel && penable && pwrite && paddr == 12'h064 |-> ##2
    {buffer_power[2:1], buffer_input_sel[5:3], buffer_input_sel[8:6]} == wd_q2[7:0])
    else $error("second terminal outputs wrong");
  AST_DRIVE_MUX: assert property (psel && penable && pwrite && paddr == 12'h068 |-> ##2
    {drive_to_positive, drive_to_negative, drive_to_measure} ==
    {wd_q2[2:0] == 3'h6, wd_q2[2:0] == 3'h7, wd_q2[3:0] == 4'hA})
    else $error("drive routing wrong");
endmodule : aux_cfg_checker
bind biopotential_aux_config_regs aux_cfg_checker i_aux_cfg_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gpio_taken, .single_shot,
  .terminal_to_drive_link, .lead_comparator_enable, .augmented_lead_route, .buffer_power,
  .buffer_input_sel, .drive_to_positive, .drive_to_negative, .drive_to_measure);
`default_nettype wire

/* File: tb/test_biopotential_aux_config_regs.sv */
// self-checking bench for the aux config register bank
`timescale 1ns/1ps
`default_nettype none
module test_biopotential_aux_config_regs;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gpio_taken, single_shot;
  logic terminal_to_drive_link, lead_comparator_enable, breathing_out_first;
  logic breathing_out_second, drive_to_positive, drive_to_negative, drive_to_measure;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [3:0] augmented_lead_route;
  logic [2:0] buffer_power;
  logic [8:0] buffer_input_sel;
  logic e, p1;
  logic [7:0] m[6] = '{8'h15, 8'h00, 8'h00, 8'h14, 8'h00, 8'h00};
  logic [7:0] mask[6] = '{8'h1F, 8'hEE, 8'hFF, 8'hFF, 8'h3F, 8'hFF};
  int mismatches, n_tests, i, k, eq, tg;
  int gr[5] = '{1, 1, 1, 1, 0};
  int gf[5] = '{0, 0, 1, 2, 0};
  int gp[5] = '{3, 7, 3, 3, 3};
  int ge[5] = '{608, 0, 608, 0, 0};
  int gn[5] = '{8, 8, 4, 2, 8};
  biopotential_aux_config_regs i_biopotential_aux_config_regs (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .breathing_out_first,
    .breathing_out_second, .gpio_taken, .single_shot, .terminal_to_drive_link,
    .lead_comparator_enable, .augmented_lead_route, .buffer_power, .buffer_input_sel,
    .drive_to_positive, .drive_to_negative, .drive_to_measure);
  // 20 MHz clock
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  // one apb transfer, request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      mismatches++;
      test_done();
    end
  endtask : apb
  task wr(input int x, input logic [31:0] d);
    apb(1'b1, 12'h058 + 12'(4 * x), d & {24'h00_0000, mask[x]});
    m[x] = d[7:0] & mask[x];
    chk(32'(e), 32'h0);
  endtask : wr
  task rd(input int x);
    apb(1'b0, 12'h058 + 12'(4 * x), 32'h0);
    chk(r, 32'(m[x]));
    chk(32'(e), 32'h0);
  endtask : rd
  // compare every configuration pin with the model
  task chk_out();
    repeat (3) @(posedge pclk);
    chk(32'(gpio_taken), 32'(m[0][0]));
    chk(32'({single_shot, terminal_to_drive_link, lead_comparator_enable}), 32'(m[1][3:1]));
    chk(32'({augmented_lead_route, buffer_power, buffer_input_sel}), 32'({m[2][7:4], m[3][7:6],
      m[2][3], m[3][2:0], m[3][5:3], m[2][2:0]}));
    chk(32'({drive_to_positive, drive_to_negative, drive_to_measure}), 32'({m[4][2:0] == 3'h6,
      m[4][2:0] == 3'h7, m[4][3:0] == 4'hA}));
  endtask : chk_out
  // main sequence
  initial begin
    seed = 32'h9A94;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++) rd(i);
    chk_out();
    for (i = 0; i < 16; i++) begin
      wr(4, i);
      if (i < 4) wr(0, i | 32'h14);
      chk_out();
    end
    for (i = 0; i < 40; i++) begin
      k = rnd() % 5;
      wr(k, rnd());
      rd(k);
      chk_out();
    end
    apb(1'b0, 12'h074, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, 12'h05D, 32'hFF);
    chk({31'h0, e}, 32'h1);
    rd(1);
    // breathing generator: phase by equal-level count, frequency by toggles
    for (i = 0; i < 5; i++) begin
      wr(5, gr[i]);
      wr(1, gf[i] << 5);
      wr(0, (gp[i] << 2) | 1);
      repeat (1300) @(posedge pclk);
      eq = 0;
      tg = 0;
      p1 = breathing_out_first;
      for (k = 0; k < 1216; k++) begin
        @(posedge pclk);
        eq += int'(breathing_out_first === breathing_out_second);
        tg += int'(breathing_out_first !== p1);
        p1 = breathing_out_first;
      end
      chk(32'(tg), 32'(gn[i]));
      chk(32'(eq >= ge[i] - 16 && eq <= ge[i] + 16), 32'h1);
    end
    test_done();
  end
endmodule : test_biopotential_aux_config_regs
`default_nettype wire
